// ==== timer_one_consts.svh ====
// How it works
// - Sixteen-bit count: timer, sync or async counter.
// - Interrupt on period match or gate fall.
// - Bit 15 starts and stops the timer.
// - Bit 13 halts the timer during idle.
// - Bits 9-8 pick the extended clock source.
// - Gate enable honoured only with internal clock.
// - Bits 5-4 divide by 1, 8, 64, 256.
// - Bit 2 synchronizes extended clock when selected.
// - Bit 1 selects extended clock, else internal.
// - Unimplemented control bits always read zero.
// - Control write while running clears prescaler.
// - Control register resets to all zeros.
`ifndef TIMER_ONE_CONSTS_SVH
`define TIMER_ONE_CONSTS_SVH

// Register word offsets; the byte address is four times this.
`define OFS_CONTROL      4'h0
`define OFS_COUNT        4'h1
`define OFS_PERIOD       4'h2
`define OFS_STATUS       4'h3
`define OFS_MASK         4'h4

// Control register field positions.
`define BIT_RUN          15
`define BIT_IDLE_STOP    13
`define BIT_EXT_HI       9
`define BIT_EXT_LO       8
`define BIT_GATE_EN      6
`define BIT_PRE_HI       5
`define BIT_PRE_LO       4
`define BIT_SYNC         2
`define BIT_CLK_SEL      1

// Writable bits of the control register.
`define CONTROL_MASK     16'ha376
`define CONTROL_RESET    16'h0000
`define PERIOD_RESET     16'hffff

// Status bit positions.
`define EV_MATCH         0
`define EV_GATE_FALL     1
`define EV_BITS          2

// Prescale terminal counts.
`define DIV_8_LAST       8'h07
`define DIV_64_LAST      8'h3f
`define DIV_256_LAST     8'hff

`endif

// ==== timer_one_pkg.sv ====
package timer_one_pkg;

  // Extended clock source codes.
  typedef enum logic [1:0] {
    SRC_SECONDARY = 2'b00,
    SRC_PIN       = 2'b01,
    SRC_LOW_POWER = 2'b10,
    SRC_NONE      = 2'b11
  } ext_src_t;

  // Prescale ratio codes.
  typedef enum logic [1:0] {
    DIV_1   = 2'b00,
    DIV_8   = 2'b01,
    DIV_64  = 2'b10,
    DIV_256 = 2'b11
  } prescale_t;

endpackage

// ==== prescale_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// Carries the raw count edge in and the prescaled tick out.
interface prescale_if;
  import timer_one_pkg::*;
  logic      src_edge;  // One raw count edge.
  logic      clear;     // Restart the divider.
  prescale_t ratio;     // Selected division ratio.
  logic      tick;      // One prescaled count pulse.

  // The timer side drives edges and controls.
  modport ctrl (output src_edge, output clear, output ratio, input tick);
  // The divider side answers with ticks.
  modport div (input src_edge, input clear, input ratio, output tick);
endinterface

`default_nettype wire

// ==== timer_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "timer_one_consts.svh"

// Divides raw count edges by the selected ratio.
module timer_prescaler (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Edge and tick exchange.
  prescale_if.div   pre
);
  import timer_one_pkg::*;

  logic [7:0] cnt_q;  // Edges seen since the last tick.
  logic [7:0] last;   // Terminal count of the ratio.

  // Picks the terminal count for the ratio.
  always_comb begin
    case (pre.ratio)
      DIV_8:   last = `DIV_8_LAST;
      DIV_64:  last = `DIV_64_LAST;
      DIV_256: last = `DIV_256_LAST;
      default: last = 8'h00;
    endcase
  end

  // Counts edges and wraps at the terminal count.
  always_ff @(posedge clk_i) begin
    if (rst_i || pre.clear) begin
      cnt_q <= 8'h00;
    end else if (pre.src_edge) begin
      cnt_q <= (cnt_q >= last) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  // Tick fires on the edge that finds the count at the terminal count.
  assign pre.tick = pre.src_edge && (cnt_q >= last);

endmodule

`default_nettype wire

// ==== timer_one.sv ====
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "timer_one_consts.svh"

// Sixteen-bit timer with period match and gate-fall interrupts.
module timer_one (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Clock sources and gate from outside.
  input  wire logic        secondary_oscillator_i,
  input  wire logic        external_count_pin_i,
  input  wire logic        low_power_rc_oscillator_i,
  input  wire logic        gate_i,
  // Device idle state from the same clock domain.
  input  wire logic        idle_i,
  // Interrupt request.
  output logic             irq_o
);
  import timer_one_pkg::*;

  // Four outside inputs share one synchronizer array: the three
  // count sources and the gate.
  localparam int NPIN = 4;  // Number of outside inputs.

  logic [15:0]         control_q;   // Control register.
  logic [15:0]         count_q;     // Running count.
  logic [15:0]         period_q;    // Period register.
  logic [`EV_BITS-1:0] status_q;    // Sticky event flags.
  logic [`EV_BITS-1:0] mask_q;      // Interrupt enables.
  logic [NPIN-1:0]     pin_raw;     // Outside inputs gathered.
  logic [NPIN-1:0]     pin_s1_q;    // First sync stage.
  logic [NPIN-1:0]     pin_s2_q;    // Second sync stage.
  logic [NPIN-1:0]     pin_s3_q;    // Third sync stage.
  logic [NPIN-1:0]     pin_q;       // Accepted pin levels.
  logic [NPIN-1:0]     pin_prev_q;  // Accepted levels one cycle back.
  logic                bus_req;     // Bus access in this cycle.
  logic                wr_count;    // Write to the count register.
  logic                wr_period;   // Write to the period register.
  logic                wr_status;   // Write-one-to-clear of status.
  logic                wr_mask;     // Write to the mask register.
  logic                sync_edge;   // Edge from the accepted level.
  logic                raw_edge;    // Edge taken straight off stages.
  logic                wr_ctrl;     // Write to control register.
  logic                run;         // Timer is advancing.
  logic                ext_sel;     // Extended clock chosen.
  logic                gated;       // Gated accumulation active.
  logic                ext_edge;    // Rising edge of chosen source.
  logic                gate_fall;   // Falling edge of the gate.
  logic                match;       // Tick at the period value.
  logic [`EV_BITS-1:0] ev_set;      // Events this cycle.
  logic [`EV_BITS-1:0] ev_clr;      // Software clears this cycle.
  logic [31:0]         rd_data;     // Read mux result.

  // Edge and tick exchange with the prescaler.
  prescale_if pre ();

  // Checks a byte address against a register word offset.
  function automatic logic hit(input logic [4:0] adr,
                               input logic [3:0] ofs);
    hit = (adr[4:2] == ofs[2:0]) && (adr[1:0] == 2'b00);
  endfunction

  // Rising edge of a level against its value one step older.
  function automatic logic rise(input logic now_v,
                                input logic old_v);
    rise = now_v && !old_v;
  endfunction

  // Orders the outside inputs for the synchronizer array.
  assign pin_raw = {gate_i, low_power_rc_oscillator_i,
                    external_count_pin_i, secondary_oscillator_i};

  // Three-stage synchronizer per input; a level is accepted
  // once the second and third stages agree.  The first stage may
  // go metastable, so nothing but the second stage ever reads it,
  // and the agree test keeps a single-cycle glitch from counting.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_s1_q[g]   <= 1'b0;
          pin_s2_q[g]   <= 1'b0;
          pin_s3_q[g]   <= 1'b0;
          pin_q[g]      <= 1'b0;
          pin_prev_q[g] <= 1'b0;
        end else begin
          pin_s1_q[g]   <= pin_raw[g];
          pin_s2_q[g]   <= pin_s1_q[g];
          pin_s3_q[g]   <= pin_s2_q[g];
          pin_prev_q[g] <= pin_q[g];
          if (pin_s2_q[g] == pin_s3_q[g]) begin
            pin_q[g] <= pin_s3_q[g];
          end
        end
      end
    end
  endgenerate

  // A new request is one not yet answered.  The master keeps cyc
  // and stb up through the acknowledge edge, so without the ack
  // term one request would be taken twice.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Per-register write strobes.  A write lands at the edge that
  // takes the request; the acknowledge follows one cycle later.
  assign wr_ctrl   = bus_req && wb_we_i && hit(wb_adr_i, `OFS_CONTROL);
  assign wr_count  = bus_req && wb_we_i && hit(wb_adr_i, `OFS_COUNT);
  assign wr_period = bus_req && wb_we_i && hit(wb_adr_i, `OFS_PERIOD);
  assign wr_status = bus_req && wb_we_i && hit(wb_adr_i, `OFS_STATUS);
  assign wr_mask   = bus_req && wb_we_i && hit(wb_adr_i, `OFS_MASK);

  // Run only when switched on and not parked by idle.  While the
  // timer stands still the prescaler is held clear, so a restart
  // always begins a fresh division.
  assign run = control_q[`BIT_RUN] &&
               !(control_q[`BIT_IDLE_STOP] && idle_i);
  // Clock source select: a set bit picks the extended sources.
  assign ext_sel = control_q[`BIT_CLK_SEL];
  // Gating applies only to the internal clock.
  assign gated = control_q[`BIT_GATE_EN] && !ext_sel;

  // Selects the rising edge of the chosen extended source, in two
  // forms.  The synchronized edge comes from the accepted level.
  // The unsynchronized edge is taken the moment the second and
  // third stages agree on high, before the accepted level follows:
  // one cycle sooner, with the same single count per rise.  The
  // block has one clock, so every source still passes the stages.
  always_comb begin
    sync_edge = 1'b0;
    raw_edge  = 1'b0;
    case (ext_src_t'(control_q[`BIT_EXT_HI:`BIT_EXT_LO]))
      SRC_SECONDARY: begin
        sync_edge = rise(pin_q[0], pin_prev_q[0]);
        raw_edge  = rise(pin_s2_q[0] && pin_s3_q[0], pin_q[0]);
      end
      SRC_PIN: begin
        sync_edge = rise(pin_q[1], pin_prev_q[1]);
        raw_edge  = rise(pin_s2_q[1] && pin_s3_q[1], pin_q[1]);
      end
      SRC_LOW_POWER: begin
        sync_edge = rise(pin_q[2], pin_prev_q[2]);
        raw_edge  = rise(pin_s2_q[2] && pin_s3_q[2], pin_q[2]);
      end
      default: begin
        // The unused code never counts.
        sync_edge = 1'b0;
        raw_edge  = 1'b0;
      end
    endcase
  end

  // The synchronize bit chooses which form of the edge counts.
  assign ext_edge = control_q[`BIT_SYNC] ? sync_edge : raw_edge;

  // Feeds the prescaler with the raw count edge.  A control write
  // while the run bit is set restarts the division, as does any
  // spell in which the timer is halted.
  always_comb begin
    pre.ratio = prescale_t'(control_q[`BIT_PRE_HI:`BIT_PRE_LO]);
    pre.clear = !run || (wr_ctrl && control_q[`BIT_RUN]);
    if (!run) begin
      pre.src_edge = 1'b0;
    end else if (ext_sel) begin
      pre.src_edge = ext_edge;
    end else if (gated) begin
      pre.src_edge = pin_q[3];
    end else begin
      pre.src_edge = 1'b1;
    end
  end

  // Divides the raw count edges down to count ticks.
  timer_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pre   (pre)
  );

  // Gate fall counts only while gated accumulation runs.
  // An idle halt does not mask it, so a fall during idle is kept.
  assign gate_fall = gated && control_q[`BIT_RUN] &&
                     pin_prev_q[3] && !pin_q[3];
  // A tick that finds the count at the period value wraps it.
  assign match = pre.tick && (count_q == period_q);

  // Control register, writable bits only.  Unimplemented bits are
  // masked off on the way in, so they always read back as zero;
  // reset leaves the timer off, on the internal clock, at 1:1.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_q <= `CONTROL_RESET;
    end else if (wr_ctrl) begin
      control_q <= wb_dat_i[15:0] & `CONTROL_MASK;
    end
  end

  // Period register.  It resets to all ones so that a timer started
  // before software loads a period still runs the full range.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_q <= `PERIOD_RESET;
    end else if (wr_period) begin
      period_q <= wb_dat_i[15:0];
    end
  end

  // Count: software write, wrap on match, else advance per tick.
  // A software write wins over a tick that lands in the same cycle,
  // so software can preset the phase of the next period.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
    end else if (wr_count) begin
      count_q <= wb_dat_i[15:0];
    end else if (match) begin
      count_q <= 16'h0000;
    end else if (pre.tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Events raised this cycle and clears from software.  Writing a
  // one clears a flag; a zero leaves it alone.
  assign ev_set = {gate_fall, match};
  assign ev_clr = wr_status ? wb_dat_i[`EV_BITS-1:0] : '0;

  // Sticky status; a new event wins over a clear in the same cycle,
  // so an event can never slip past software unseen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  // Interrupt mask register.
  // A set bit lets the matching status flag reach the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= wb_dat_i[`EV_BITS-1:0];
    end
  end

  // Level interrupt while any unmasked flag is set.  It is taken
  // from a flop so the pin never glitches while flags change, at
  // the cost of one cycle of delay.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  // Read mux; unmapped addresses read zero.  Status and mask use
  // only their low bits and the control register its implemented
  // ones, so every unused bit reads zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(wb_adr_i, `OFS_CONTROL)) begin
      rd_data[15:0] = control_q;
    end else if (hit(wb_adr_i, `OFS_COUNT)) begin
      rd_data[15:0] = count_q;
    end else if (hit(wb_adr_i, `OFS_PERIOD)) begin
      rd_data[15:0] = period_q;
    end else if (hit(wb_adr_i, `OFS_STATUS)) begin
      rd_data[`EV_BITS-1:0] = status_q;
    end else if (hit(wb_adr_i, `OFS_MASK)) begin
      rd_data[`EV_BITS-1:0] = mask_q;
    end
  end

  // Acknowledge one cycle after a request, for one cycle.  A master
  // that keeps its request up through the acknowledge is not taken
  // a second time, because the request term is gated by the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data is registered with the acknowledge.  It then holds
  // until the next request is taken, so a master may sample it at
  // the acknowledge edge or later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule

`default_nettype wire

// ==== timer_one_properties.sv ====
`timescale 1ns/10ps
`default_nettype none

// Checks the bus handshake, the read masks and the interrupt pin.
module timer_one_checker (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus and interrupt pins.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take; // A request is taken at this edge.
  logic       rd_q; // A read was taken at the previous edge.
  logic [4:0] ra_q; // Address on the bus at the previous edge.
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Remembers each read so that its answer can be judged.
  always_ff @(posedge clk_i) begin
    rd_q <= take && !wb_we_i && !rst_i;
    ra_q <= wb_adr_i;
  end
  ack_one_shot_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one cycle pulse");
  ack_cause_a: assert property (wb_ack_o |-> $past(take))
    else $error("ack without a request");
  ctrl_pad_a: assert property (wb_ack_o && rd_q && ra_q == 5'h00
    |-> (wb_dat_o & 32'hffff5c89) == 32'h0) else $error("control pad set");
  stat_pad_a: assert property (wb_ack_o && rd_q && ra_q == 5'h0c
    |-> wb_dat_o[31:2] == 30'h0) else $error("status pad set");
  hole_zero_a: assert property (wb_ack_o && rd_q && ra_q == 5'h14
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  data_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between requests");
  rst_quiet_a: assert property ($past(rst_i) |-> !wb_ack_o && !irq_o)
    else $error("outputs active after reset");
  mask_off_a: assert property (take && wb_we_i && wb_adr_i == 5'h10
    && wb_dat_i[1:0] == 2'h0 |=> ##1 !irq_o) else $error("masked irq high");
  cover property (take && wb_we_i);
  cover property ($rose(irq_o));
  cover property (wb_ack_o && rd_q && ra_q == 5'h0c);
endmodule

bind timer_one timer_one_checker timer_one_checker_inst (.*);

`default_nettype wire

// ==== timer_ext_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Far side: slow count sources that idle low, and the gate line.
module timer_ext_model (
  // Pacing clock.
  input  wire logic clk_i,
  // Sources and gate.
  output logic      sec_o,
  output logic      pin_o,
  output logic      low_power_rc_oscillator_o,
  output var logic  gate_o
);
  logic [2:0] osc_q = 3'h0; // Source lines, still between bursts.
  assign {low_power_rc_oscillator_o, pin_o, sec_o} = osc_q;
  initial gate_o = 1'b0;
  // Sends n rising edges, four cycles high and four low.
  task automatic burst(input int s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      osc_q[s] <= 1'b1;
      repeat (4) @(posedge clk_i);
      osc_q[s] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // Moves the gate line after an edge.
  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
  endtask
endmodule

`default_nettype wire

// ==== timer_one_test.sv ====
`timescale 1ns/10ps
`default_nettype none

// Drives the timer over its bus and checks what it reports.
module timer_one_test;
  logic        clk_i = 1'b0; // Bench clock.
  logic        rst_i = 1'b1; // Synchronous reset.
  logic        cyc = 1'b0;   // Bus request.
  logic        we = 1'b0;    // Write strobe.
  logic [4:0]  adr = 5'h00;  // Byte address.
  logic [31:0] wdat = 32'h0; // Write data.
  logic [31:0] rdat;         // Read data.
  logic        ack;          // Acknowledge.
  logic        idle = 1'b0;  // Device idle.
  logic        irq;          // Interrupt.
  wire         sec, pin, low_power_rc_oscillator, gate;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [31:0] q;
  int          r[3] = '{8, 64, 256}; // Ratios for codes 1 to 3.
  timer_one timer_one_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .secondary_oscillator_i(sec), .external_count_pin_i(pin),
    .low_power_rc_oscillator_i(low_power_rc_oscillator), .gate_i(gate), .idle_i(idle),
    .irq_o(irq));
  timer_ext_model timer_ext_model_inst (.clk_i(clk_i), .sec_o(sec),
    .pin_o(pin), .low_power_rc_oscillator_o(low_power_rc_oscillator), .gate_o(gate));
  always #25 clk_i = ~clk_i;
  // One classic cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  // Reads a register and compares the whole word.
  task automatic chk(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    cmp_count++;
    if (q !== {16'h0, e}) begin
      n_errors++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, q);
    end
  endtask
  // Compares the interrupt pin once the last write has landed.
  task automatic chk_irq(input logic e);
    @(posedge clk_i);
    cmp_count++;
    if (irq !== e) begin
      n_errors++;
      $display("CHECK FAILED irq expected %b seen %b", e, irq);
    end
  endtask
  // Clears the count, runs with control c for n cycles, stops.
  task automatic go(input logic [15:0] c, input int n);
    wr(5'h04, 16'h0);
    wr(5'h00, c);
    repeat (n) @(posedge clk_i);
    wr(5'h00, 16'h0);
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(5'h00, 16'h0000);
    chk(5'h08, 16'hffff);
    chk(5'h0c, 16'h0000);
    chk(5'h10, 16'h0000);
    wr(5'h00, 16'h7fff);
    chk(5'h00, 16'h2376);
    wr(5'h14, 16'hffff);
    chk(5'h14, 16'h0000);
    idle <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      go(16'h8010 + 16'(k << 4), r[k] * 7 / 2 - 2);
      chk(5'h04, 16'h0003);
    end
    wr(5'h04, 16'h0);
    wr(5'h00, 16'h8010);
    repeat (6) wr(5'h00, 16'h8010);
    wr(5'h00, 16'h0);
    chk(5'h04, 16'h0000);
    go(16'ha000, 20);
    chk(5'h04, 16'h0000);
    idle <= 1'b0;
    wr(5'h08, 16'h0002);
    wr(5'h10, 16'h0001);
    go(16'h8010, 26);
    chk(5'h04, 16'h0000);
    chk(5'h0c, 16'h0001);
    chk_irq(1'b1);
    wr(5'h10, 16'h0000);
    chk_irq(1'b0);
    wr(5'h10, 16'h0001);
    wr(5'h0c, 16'h0001);
    chk_irq(1'b0);
    wr(5'h08, 16'hffff);
    wr(5'h10, 16'h0002);
    go(16'h8040, 20);
    chk(5'h04, 16'h0000);
    wr(5'h00, 16'h8040);
    timer_ext_model_inst.set_gate(1'b1);
    repeat (10) @(posedge clk_i);
    timer_ext_model_inst.set_gate(1'b0);
    repeat (10) @(posedge clk_i);
    wr(5'h00, 16'h0);
    chk(5'h04, 16'h000b);
    chk(5'h0c, 16'h0002);
    chk_irq(1'b1);
    wr(5'h0c, 16'h0002);
    chk_irq(1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(5'h04, 16'h0);
      wr(5'h00, 16'h8042 | 16'(s << 8) | 16'(s[0] << 2));
      timer_ext_model_inst.burst(s == 3 ? 1 : s, 5);
      repeat (8) @(posedge clk_i);
      wr(5'h00, 16'h0);
      chk(5'h04, s == 3 ? 16'h0 : 16'h5);
    end
    stop_test();
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule

`default_nettype wire
